// ### hw/swdt_pkg.sv
// Package of constants for the system watchdog timer
package swdt_pkg;

    // ========================================
    // Register map
    // ========================================
    // Printed offsets are not all word aligned, so they act as register
    // indices; the byte address within the block is four times the index.
    localparam logic [31:0] SWDT_BASE_IDX  = 32'h5000_3100;
    localparam logic [31:0] SWDT_COUNT_IDX = 32'h5000_3100;
    localparam logic [31:0] SWDT_CTRL_IDX  = 32'h5000_3102;
    localparam logic [11:0] SWDT_COUNT_ADDR = 12'((SWDT_COUNT_IDX - SWDT_BASE_IDX) * 4);
    localparam logic [11:0] SWDT_CTRL_ADDR  = 12'((SWDT_CTRL_IDX - SWDT_BASE_IDX) * 4);

    // ========================================
    // Field layout
    // ========================================
    localparam int SWDT_KEY_MSB  = 15;
    localparam int SWDT_KEY_LSB  = 9;
    localparam int SWDT_SIGN_POS = 8;
    localparam int SWDT_MODE_POS = 0;
    localparam int SWDT_SPARE_POS = 1;

    // ========================================
    // Values
    // ========================================
    localparam logic [8:0] SWDT_COUNT_RST  = 9'h0ff;
    localparam logic [8:0] SWDT_RELOAD     = 9'h0ff;
    localparam logic [8:0] SWDT_NMI_LEVEL  = 9'h000;
    localparam logic [8:0] SWDT_RST_LEVEL  = 9'h1f0;
    localparam logic [6:0] SWDT_KEY_OPEN   = 7'h00;
    localparam logic       SWDT_MODE_RST   = 1'b0;
    localparam logic       SWDT_SPARE_RST  = 1'b0;

    // ========================================
    // Timing
    // ========================================
    localparam int SWDT_CLK_PERIOD_NS  = 20;
    localparam int SWDT_TICK_PERIOD_NS = 10240000;
    localparam int SWDT_TICK_CYCLES    = SWDT_TICK_PERIOD_NS / SWDT_CLK_PERIOD_NS;

endpackage

// ### hw/swdt_top.sv
// System watchdog timer with APB register slave
//
// Contract
// - Count reload only when write key bits 15:9 are all zero.
// - Decrement once per 10.24 ms tick; reads return live count.
// - Count is 9-bit two's complement; in mode clear zero wraps to 0x1ff.
// - Mode clear: NMI when count reaches zero; freeze request honoured.
// - Mode clear: watchdog reset at 0x1f0, then reload 0xff.
// - Mode set: watchdog reset when count zero or negative, reload 0xff.
// - Mode set: freeze requests ignored, counting continues.
// - Mode bit set-only by software; cleared by watchdog or software reset.
// - Count halts while the core is halted in debug.
`timescale 1ns/1ns

module swdt_top
    import swdt_pkg::*;
#(
    parameter int TICK_CYCLES = SWDT_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // System controls
    input  wire logic        freeze_request_bit,
    input  wire logic        debug_halt,
    input  wire logic        sw_reset,
    // Events
    output logic             nmi_pulse,
    output logic             wdog_reset_pulse
);

    localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    // ========================================
    // State
    // ========================================
    logic [8:0]    count_q;
    logic [8:0]    count_d;
    logic          mode_q;
    logic          mode_d;
    logic          spare_q;
    logic          spare_d;
    logic [TW-1:0] div_q;
    logic [TW-1:0] div_d;
    logic          nmi_q;
    logic          wrst_q;
    logic [31:0]   rdata_q;

    // ========================================
    // Bus decode
    // ========================================
    wire setup_rd   = psel && !penable && !pwrite;
    wire access     = psel && penable;
    wire hit_count  = paddr == SWDT_COUNT_ADDR;
    wire hit_ctrl   = paddr == SWDT_CTRL_ADDR;
    wire mapped     = hit_count || hit_ctrl;
    wire wr_count   = access && pwrite && hit_count;
    wire wr_ctrl    = access && pwrite && hit_ctrl;
    wire key_ok     = pwdata[SWDT_KEY_MSB:SWDT_KEY_LSB] == SWDT_KEY_OPEN;
    wire reload_wr  = wr_count && key_ok;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = rdata_q;

    wire [31:0] rd_mux = hit_count ? {23'h0, count_q} :
                         hit_ctrl  ? {30'h0, spare_q, mode_q} : 32'h0;

    // ========================================
    // Tick and countdown
    // ========================================
    // The divider runs free so that freezing never stretches a tick period.
    wire tick = div_q == TICK_LAST;
    assign div_d = tick ? '0 : div_q + TW'(1);

    // software freeze honoured in interrupt mode only
    // freeze ignored once the mode bit is set
    // debug halt freezes in both modes
    wire frozen = debug_halt || (freeze_request_bit && !mode_q);
    wire dec    = tick && !frozen;
    wire [8:0] count_dec = count_q - 9'h001;

    // zero or negative in reset mode
    wire trig = mode_q ? (count_q == SWDT_NMI_LEVEL || count_q[SWDT_SIGN_POS])
                       : (count_q == SWDT_RST_LEVEL);
    // interrupt when the count steps onto zero
    wire nmi_set = dec && !mode_q && !trig && !reload_wr && count_dec == SWDT_NMI_LEVEL;

    always_comb
    begin
        count_d = count_q;
        if (trig)
        begin
            count_d = SWDT_RELOAD;
        end
        else if (reload_wr)
        begin
            count_d = {1'b0, pwdata[7:0]};
        end
        else if (dec)
        begin
            count_d = count_dec;
        end
    end

    // ========================================
    // Control register
    // ========================================
    always_comb
    begin
        mode_d  = mode_q;
        spare_d = spare_q;
        if (wr_ctrl)
        begin
            mode_d  = mode_q | pwdata[SWDT_MODE_POS];
            spare_d = pwdata[SWDT_SPARE_POS];
        end
        if (trig || sw_reset)
        begin
            mode_d = SWDT_MODE_RST;
        end
    end

    // ========================================
    // Registers
    // ========================================
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_q <= SWDT_COUNT_RST;
            mode_q  <= SWDT_MODE_RST;
            spare_q <= SWDT_SPARE_RST;
            div_q   <= '0;
            nmi_q   <= 1'b0;
            wrst_q  <= 1'b0;
            rdata_q <= 32'h0;
        end
        else
        begin
            count_q <= count_d;
            mode_q  <= mode_d;
            spare_q <= spare_d;
            div_q   <= div_d;
            nmi_q   <= nmi_set;
            wrst_q  <= trig;
            if (setup_rd)
            begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign nmi_pulse        = nmi_q;
    assign wdog_reset_pulse = wrst_q;

    // ========================================
    // Step spacing check
    // ========================================
    // running count moves once per period
    // A lost tick would let the gap pass one full period.
    localparam int            GW      = TW + 1;
    localparam logic [GW-1:0] GAP_MAX = GW'(TICK_CYCLES);

    logic [8:0]    seen_q;
    logic [GW-1:0] gap_q;

    wire moved = count_q != seen_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            seen_q <= SWDT_COUNT_RST;
            gap_q  <= '0;
        end
        else
        begin
            seen_q <= count_q;
            if (moved || frozen || reload_wr)
            begin
                gap_q <= '0;
            end
            else
            begin
                gap_q <= gap_q + GW'(1);
            end
        end
    end

    // ========================================
    // Assertions
    // ========================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    key_reject_a: assert property (
        wr_count && !key_ok && !trig && !dec |=> $stable(count_q))
        else $error("Keyed-off write changed the count");

    key_accept_a: assert property (
        reload_wr && !trig |=> count_q == {1'b0, $past(pwdata[7:0])})
        else $error("Accepted reload not loaded with sign clear");

    tick_step_a: assert property (
        dec && !reload_wr && !trig |=> count_q == $past(count_q) - 9'h001)
        else $error("Count did not step on tick");

    wrap_neg_a: assert property (
        dec && !reload_wr && !trig && count_q == 9'h000 |=> count_q == 9'h1ff)
        else $error("Zero did not wrap to 0x1ff");

    nmi_zero_a: assert property (
        nmi_pulse |-> count_q == SWDT_NMI_LEVEL && !$past(mode_q))
        else $error("NMI without zero count in interrupt mode");

    rst_level_a: assert property (
        !mode_q && count_q == SWDT_RST_LEVEL |=> wdog_reset_pulse && count_q == 9'h0ff && !mode_q)
        else $error("No reset and reload at 0x1f0");

    rst_mode_a: assert property (
        mode_q && (count_q[8] || count_q == 9'h000) |=> wdog_reset_pulse && !nmi_pulse && count_q == 9'h0ff)
        else $error("Reset mode did not fire at zero or below");

    freeze_ign_a: assert property (
        mode_q && tick && !debug_halt && freeze_request_bit && !trig && !reload_wr
        |=> count_q == $past(count_q) - 9'h001)
        else $error("Freeze honoured in reset mode");

    mode_sticky_a: assert property (
        mode_q && !trig && !sw_reset |=> mode_q)
        else $error("Mode bit cleared by software");

    halt_hold_a: assert property (
        debug_halt && !reload_wr && !trig |=> $stable(count_q))
        else $error("Count moved during debug halt");

    step_gap_a: assert property (
        gap_q <= GAP_MAX)
        else $error("Running count missed a tick");

    step_only_a: assert property (
        !dec && !reload_wr && !trig |=> $stable(count_q))
        else $error("Count moved without tick, reload or trigger");

    read_live_a: assert property (
        setup_rd && hit_count |=> prdata == {23'h0, $past(count_q)})
        else $error("Count read did not return the live count");

    nmi_raise_a: assert property (
        dec && !mode_q && !trig && !reload_wr && count_q == 9'h001 |=> nmi_pulse)
        else $error("No NMI when the count stepped onto zero");

    freeze_hold_a: assert property (
        !mode_q && freeze_request_bit && !reload_wr && !trig |=> $stable(count_q))
        else $error("Count moved while frozen in interrupt mode");

    nmi_single_a: assert property (
        nmi_pulse |=> !nmi_pulse)
        else $error("NMI pulse longer than one cycle");

    rst_only_a: assert property (
        !mode_q && count_q != 9'h1f0 |=> !wdog_reset_pulse)
        else $error("Watchdog reset away from 0x1f0 in interrupt mode");

    rst_safe_a: assert property (
        mode_q && !count_q[8] && count_q != 9'h000 |=> !wdog_reset_pulse)
        else $error("Watchdog reset on a positive count in reset mode");

    no_nmi_a: assert property (
        mode_q |=> !nmi_pulse)
        else $error("NMI raised in reset mode");

    mode_set_a: assert property (
        wr_ctrl && pwdata[SWDT_MODE_POS] && !trig && !sw_reset |=> mode_q)
        else $error("Software could not set the mode bit");

    sw_clear_a: assert property (
        sw_reset |=> !mode_q)
        else $error("Software reset left the mode bit set");

    read_ctrl_a: assert property (
        setup_rd && hit_ctrl |=> prdata[SWDT_MODE_POS] == $past(mode_q))
        else $error("Control read did not return the mode bit");

    halt_quiet_a: assert property (
        debug_halt |=> !nmi_pulse)
        else $error("NMI raised during debug halt");

    nmi_cv: cover property (nmi_pulse);
    rst_cv: cover property (wdog_reset_pulse && $past(mode_q));
    reload_cv: cover property (reload_wr ##1 dec);
    err_cv: cover property (pslverr);
    halt_cv: cover property (debug_halt && tick);

endmodule // swdt_top

// ### tb/test_system_watchdog_timer.sv
// Self-checking testbench for the system watchdog timer
`timescale 1ns/1ns

module test_system_watchdog_timer
    import swdt_pkg::*;
;
    // ========================================
    // Stimulus and observation
    // ========================================
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        freeze_request_bit = 1'b0;
    logic        debug_halt = 1'b1;
    logic        sw_reset   = 1'b0;
    logic        nmi_pulse;
    logic        wdog_reset_pulse;
    logic [31:0] rd;
    logic        err;
    int          n_errors   = 0;
    int          n_compared = 0;
    int          cyc        = 0;
    int          c;

    // Short tick keeps the wrap and the 0x1f0 reset reachable in a few hundred cycles
    swdt_top #(.TICK_CYCLES(8)) u_swdt_top (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .freeze_request_bit(freeze_request_bit),
        .debug_halt(debug_halt), .sw_reset(sw_reset), .nmi_pulse(nmi_pulse),
        .wdog_reset_pulse(wdog_reset_pulse));

    always #10 sys_clk = ~sys_clk;

    // ========================================
    // Shared tasks
    // ========================================
    task final_report();
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Holds the request until pready is sampled high, then releases
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, rd);
    endtask

    // ========================================
    // Scenarios
    // ========================================
    // Count held by debug halt so reset values and reload filtering are exact
    task t_static();
        rchk("count reset", SWDT_COUNT_ADDR, 32'h0000_00ff);
        rchk("ctrl reset", SWDT_CTRL_ADDR, 32'h0000_0000);
        apb(1'b1, SWDT_COUNT_ADDR, 32'h0000_0155);
        rchk("reload sign clear", SWDT_COUNT_ADDR, 32'h0000_0055);
        apb(1'b1, SWDT_COUNT_ADDR, 32'h0000_8033);
        rchk("key bit15", SWDT_COUNT_ADDR, 32'h0000_0055);
        apb(1'b1, SWDT_COUNT_ADDR, 32'h0000_0222);
        rchk("key bit9", SWDT_COUNT_ADDR, 32'h0000_0055);
        repeat (40) @(posedge sys_clk);
        rchk("halted count", SWDT_COUNT_ADDR, 32'h0000_0055);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask

    task t_mode0();
        debug_halt <= 1'b0;
        apb(1'b1, SWDT_COUNT_ADDR, 32'h0000_0002);
        for (c = 0; c < 100 && nmi_pulse !== 1'b1; c++) @(posedge sys_clk);
        chk("nmi seen", 32'h1, {31'h0, nmi_pulse});
        rchk("count at nmi", SWDT_COUNT_ADDR, 32'h0000_0000);
        repeat (5) @(posedge sys_clk);
        rchk("wrap", SWDT_COUNT_ADDR, 32'h0000_01ff);
        for (c = 10; c < 300 && wdog_reset_pulse !== 1'b1; c++) @(posedge sys_clk);
        chk("reset at 1f0", 32'h1, {31'h0, (c > 124 && c < 136)});
        rchk("reload ff", SWDT_COUNT_ADDR, 32'h0000_00ff);
    endtask

    task t_freeze0();
        freeze_request_bit <= 1'b1;
        apb(1'b1, SWDT_COUNT_ADDR, 32'h0000_0040);
        repeat (40) @(posedge sys_clk);
        rchk("frozen mode0", SWDT_COUNT_ADDR, 32'h0000_0040);
        freeze_request_bit <= 1'b0;
    endtask

    task t_mode_bit();
        apb(1'b1, SWDT_CTRL_ADDR, 32'h0000_0003);
        rchk("mode set", SWDT_CTRL_ADDR, 32'h0000_0003);
        apb(1'b1, SWDT_CTRL_ADDR, 32'h0000_0000);
        rchk("mode sticky", SWDT_CTRL_ADDR, 32'h0000_0001);
        @(posedge sys_clk);
        sw_reset <= 1'b1;
        @(posedge sys_clk);
        sw_reset <= 1'b0;
        rchk("sw reset", SWDT_CTRL_ADDR, 32'h0000_0000);
    endtask

    task t_mode1();
        apb(1'b1, SWDT_CTRL_ADDR, 32'h0000_0001);
        freeze_request_bit <= 1'b1;
        apb(1'b1, SWDT_COUNT_ADDR, 32'h0000_0040);
        repeat (40) @(posedge sys_clk);
        apb(1'b0, SWDT_COUNT_ADDR, 32'h0000_0000);
        chk("freeze ignored", 32'h1, {31'h0, (rd < 32'h40 && rd > 32'h38)});
        freeze_request_bit <= 1'b0;
        apb(1'b1, SWDT_COUNT_ADDR, 32'h0000_0000);
        for (c = 0; c < 4 && wdog_reset_pulse !== 1'b1; c++) @(posedge sys_clk);
        chk("reset at zero", 32'h1, {31'h0, wdog_reset_pulse});
        chk("no nmi", 32'h0, {31'h0, nmi_pulse});
        rchk("mode cleared", SWDT_CTRL_ADDR, 32'h0000_0000);
    endtask

    // ========================================
    // Sequence and timeout
    // ========================================
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            final_report();
        end
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        t_static();
        t_mode0();
        t_freeze0();
        t_mode_bit();
        t_mode1();
        final_report();
    end
endmodule // test_system_watchdog_timer
